// file: common/power_mode_pkg.sv
// Constants, register map and mode encoding of the operating mode power controller
package power_mode_pkg;

    localparam int ADDR_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_POWER_CONTROL   = 8'h87;
    localparam logic [7:0] IDX_PORT_ONE_WAKE   = 8'h91;
    localparam logic [7:0] IDX_LOW_CLOCK_KEEP  = 8'hc6;
    localparam logic [7:0] IDX_CLOCK_SELECT    = 8'he5;
    localparam logic [7:0] IDX_PERIPH_CTRL     = 8'hf0;
    localparam logic [7:0] IDX_MODE_STATUS     = 8'hf1;

    // Power control fields
    localparam int PC_IDLE_BIT = 0;
    localparam int PC_STOP_BIT = 1;
    localparam int PC_GP_BIT   = 2;

    // Clock select fields
    localparam int CS_FAST_XTAL_BIT = 0;
    localparam int CS_LOW_SRC_BIT   = 7;

    // Low clock keep field
    localparam int LK_KEEP_BIT = 0;

    // Peripheral control fields
    localparam int PR_T0_RUN_BIT     = 0;
    localparam int PR_T0_CLK_LOW_BIT = 1;
    localparam int PR_ADC_CLK_LOW_BIT = 2;
    localparam int PR_LCD_EN_BIT     = 3;
    localparam int PR_ADC_EN_BIT     = 4;
    localparam int PR_T1_RUN_BIT     = 5;
    localparam int PR_SYS_PERIPH_BIT = 6;

    // Reset values
    localparam logic [2:0] POWER_CONTROL_RST = 3'h0;
    localparam logic [7:0] PORT_ONE_WAKE_RST = 8'h00;
    localparam logic       LOW_CLOCK_KEEP_RST = 1'b0;
    localparam logic       LOW_SRC_SEL_RST   = 1'b1;
    localparam logic       FAST_XTAL_RST     = 1'b0;
    localparam logic [6:0] PERIPH_CTRL_RST   = 7'h00;

    // Stop wake stabilisation counts
    localparam logic [11:0] FAST_XTAL_WARMUP = 12'd2048;
    localparam logic [11:0] FAST_RC_WARMUP   = 12'd64;
    localparam logic [2:0]  SLOW_RC_WARMUP   = 3'd5;

    // Interrupt source positions
    localparam int IRQ_N      = 8;
    localparam int IRQ_T0     = 0;
    localparam int IRQ_LCD    = 1;
    localparam int IRQ_ADC    = 2;
    localparam int IRQ_T1     = 3;
    localparam int IRQ_UART   = 4;
    localparam int IRQ_I2C    = 5;
    localparam int IRQ_PWM    = 6;
    localparam int IRQ_EXT    = 7;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_IDLE   = 4'b0010,
        MODE_STOP   = 4'b0100,
        MODE_WARMUP = 4'b1000
    } mode_e;

endpackage : power_mode_pkg

// file: logic/pin_change_detect.sv
// Level change detector for one wake-capable port
`timescale 1ns/100ps
`default_nettype none
module pin_change_detect #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] pins_i,
    input  wire logic [WIDTH-1:0] enable_i,
    input  wire logic             arm_i,
    output logic                  change_o
);
    logic [WIDTH-1:0] last_level;

    // Previous level tracked always so that arming never sees a stale value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_level <= '0;
        end else if (ce_i) begin
            last_level <= pins_i;
        end
    end

    // Either edge counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_o <= 1'b0;
        end else if (ce_i) begin
            change_o <= arm_i && (|((pins_i ^ last_level) & enable_i));
        end
    end
endmodule : pin_change_detect
`default_nettype wire

// file: logic/operating_mode_power_controller.sv
// Operating mode power controller: modes, clock gates, wake logic and register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Three modes, normal, idle and stop, govern oscillators, execution and peripherals.
// - Normal and idle run selected fast source only; stop halts both fast oscillators.
// - In stop slow RC runs if keep bit and source select are 1, or watchdog.
// - Slow crystal runs when source select is 0; in stop also needs keep bit.
// - Instructions execute only in normal mode.
// - Timer zero follows run bit; in stop needs low clock source and keep bit.
// - Idle keeps system-clocked peripherals; stop halts timers one to four, PWM, UART, I2C.
// - ADC runs in stop only on low clock with keep bit set.
// - Watchdog operation depends only on its nonvolatile option.
// - In stop only LCD, ADC, timer zero interrupts live; external interrupts dead.
// - Normal mode after reset and after every wake-up.
// - Setting stop bit enters stop; hardware clears it on wake.
// - Setting idle bit enters idle; hardware clears it on wake.
// - Stop retains all registers and control state.
// - Idle wakes on port change, reset, or enabled interrupt with global enable.
// - Stop wakes on port change, reset, or qualified LCD, ADC, timer zero interrupt.
// - Interrupt wake sets its request flag so the service routine runs.
// - Stop wake waits 2048 or 64 fast clocks plus 5 slow RC clocks.
// - Wake pins trigger on rising or falling change in stop or idle.
// - Port zero always wakes; port one pins wake only when enabled.
// - Idle at bit 0, stop at bit 1 of power control, both reset zero.
module operating_mode_power_controller (
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    input  wire logic                                  ce_i,
    input  wire logic [power_mode_pkg::ADDR_W-1:0]     address_i,
    input  wire logic                                  read_i,
    input  wire logic                                  write_i,
    input  wire logic [31:0]                           writedata_i,
    input  wire logic [3:0]                            byteenable_i,
    output logic      [31:0]                           readdata_o,
    output logic                                       waitrequest_o,
    input  wire logic [7:0]                            port_zero_i,
    input  wire logic [7:0]                            port_one_i,
    input  wire logic [power_mode_pkg::IRQ_N-1:0]      irq_event_i,
    input  wire logic [power_mode_pkg::IRQ_N-1:0]      irq_enable_i,
    input  wire logic                                  global_irq_enable_i,
    input  wire logic                                  watchdog_option_i,
    input  wire logic                                  fast_tick_i,
    input  wire logic                                  slow_tick_i,
    output logic                                       internal_fast_rc_osc_en_o,
    output logic                                       fast_crystal_en_o,
    output logic                                       internal_slow_rc_osc_en_o,
    output logic                                       slow_crystal_en_o,
    output logic                                       cpu_clock_en_o,
    output logic                                       timer_zero_clock_en_o,
    output logic                                       timer_one_clock_en_o,
    output logic                                       sys_periph_clock_en_o,
    output logic                                       lcd_clock_en_o,
    output logic                                       adc_clock_en_o,
    output logic                                       watchdog_clock_en_o,
    output logic                                       ext_irq_en_o,
    output logic [power_mode_pkg::IRQ_N-1:0]           irq_flag_set_o
);
    power_mode_pkg::mode_e mode;
    power_mode_pkg::mode_e next_mode;

    logic        idle_req;
    logic        stop_req;
    logic        gp_flag;
    logic [7:0]  port_one_wake_enable;
    logic        stop_keep_low_clock;
    logic        low_clock_source_select;
    logic        fast_is_crystal;
    logic [6:0]  periph_ctrl;
    logic [11:0] fast_count;
    logic [2:0]  slow_count;

    logic [7:0]  reg_index;
    logic        aligned;
    logic        write_take;
    logic        wr_lane0;
    logic [7:0]  read_value;

    logic        wake_armed;
    logic        port_zero_change;
    logic        port_one_change;
    logic        pin_wake;
    logic [power_mode_pkg::IRQ_N-1:0] stop_irq_mask;
    logic [power_mode_pkg::IRQ_N-1:0] idle_wake_irqs;
    logic [power_mode_pkg::IRQ_N-1:0] stop_wake_irqs;
    logic        idle_wake;
    logic        stop_wake;
    logic        warmup_done;
    logic [11:0] fast_target;

    logic        t0_low;
    logic        adc_low;

    assign reg_index  = address_i[power_mode_pkg::ADDR_W-1:2];
    assign aligned    = (address_i[1:0] == 2'h0);
    assign write_take = write_i && !waitrequest_o && aligned;
    assign wr_lane0   = write_take && byteenable_i[0];

    assign t0_low  = periph_ctrl[power_mode_pkg::PR_T0_CLK_LOW_BIT];
    assign adc_low = periph_ctrl[power_mode_pkg::PR_ADC_CLK_LOW_BIT];

    // Bus slave: one wait cycle, then the access completes on the edge seeing waitrequest low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waitrequest_o <= 1'b1;
        end else if (ce_i) begin
            if ((read_i || write_i) && waitrequest_o) begin
                waitrequest_o <= 1'b0;
            end else begin
                waitrequest_o <= 1'b1;
            end
        end
    end

    // Unmapped or misaligned reads return zero
    always_comb begin
        read_value = 8'h00;
        if (!aligned) begin
            read_value = 8'h00;
        end else if (reg_index == power_mode_pkg::IDX_POWER_CONTROL) begin
            read_value = {5'h00, gp_flag, stop_req, idle_req};
        end else if (reg_index == power_mode_pkg::IDX_PORT_ONE_WAKE) begin
            read_value = port_one_wake_enable;
        end else if (reg_index == power_mode_pkg::IDX_LOW_CLOCK_KEEP) begin
            read_value = {7'h00, stop_keep_low_clock};
        end else if (reg_index == power_mode_pkg::IDX_CLOCK_SELECT) begin
            read_value = {low_clock_source_select, 6'h00, fast_is_crystal};
        end else if (reg_index == power_mode_pkg::IDX_PERIPH_CTRL) begin
            read_value = {1'b0, periph_ctrl};
        end else if (reg_index == power_mode_pkg::IDX_MODE_STATUS) begin
            read_value = {3'h0, watchdog_option_i, mode};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            readdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (read_i && waitrequest_o) begin
                readdata_o <= {24'h00_0000, read_value};
            end
        end
    end

    // Mode request bits; a write in the wake cycle wins over the hardware clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {gp_flag, stop_req, idle_req} <= power_mode_pkg::POWER_CONTROL_RST;
        end else if (ce_i) begin
            if (wr_lane0 && reg_index == power_mode_pkg::IDX_POWER_CONTROL) begin
                idle_req <= writedata_i[power_mode_pkg::PC_IDLE_BIT];
                stop_req <= writedata_i[power_mode_pkg::PC_STOP_BIT];
                gp_flag  <= writedata_i[power_mode_pkg::PC_GP_BIT];
            end else if (mode == power_mode_pkg::MODE_IDLE && idle_wake) begin
                idle_req <= 1'b0;
                stop_req <= 1'b0;
            end else if (mode == power_mode_pkg::MODE_STOP && stop_wake) begin
                stop_req <= 1'b0;
                idle_req <= 1'b0;
            end
        end
    end

    // Configuration registers; untouched by mode changes so stop retains them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_one_wake_enable    <= power_mode_pkg::PORT_ONE_WAKE_RST;
            stop_keep_low_clock     <= power_mode_pkg::LOW_CLOCK_KEEP_RST;
            low_clock_source_select <= power_mode_pkg::LOW_SRC_SEL_RST;
            fast_is_crystal         <= power_mode_pkg::FAST_XTAL_RST;
            periph_ctrl             <= power_mode_pkg::PERIPH_CTRL_RST;
        end else if (ce_i && wr_lane0) begin
            if (reg_index == power_mode_pkg::IDX_PORT_ONE_WAKE) begin
                port_one_wake_enable <= writedata_i[7:0];
            end else if (reg_index == power_mode_pkg::IDX_LOW_CLOCK_KEEP) begin
                stop_keep_low_clock <= writedata_i[power_mode_pkg::LK_KEEP_BIT];
            end else if (reg_index == power_mode_pkg::IDX_CLOCK_SELECT) begin
                low_clock_source_select <= writedata_i[power_mode_pkg::CS_LOW_SRC_BIT];
                fast_is_crystal         <= writedata_i[power_mode_pkg::CS_FAST_XTAL_BIT];
            end else if (reg_index == power_mode_pkg::IDX_PERIPH_CTRL) begin
                periph_ctrl <= writedata_i[6:0];
            end
        end
    end

    // Wake pins watched only while asleep
    assign wake_armed = (mode == power_mode_pkg::MODE_IDLE) || (mode == power_mode_pkg::MODE_STOP);

    pin_change_detect #(
        .WIDTH (8)
    ) port_zero_watch (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .pins_i   (port_zero_i),
        .enable_i (8'hff),
        .arm_i    (wake_armed),
        .change_o (port_zero_change)
    );

    pin_change_detect #(
        .WIDTH (8)
    ) port_one_watch (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .pins_i   (port_one_i),
        .enable_i (port_one_wake_enable),
        .arm_i    (wake_armed),
        .change_o (port_one_change)
    );

    assign pin_wake = port_zero_change || port_one_change;

    // Only low-clocked LCD, ADC and timer zero survive stop
    always_comb begin
        stop_irq_mask = '0;
        stop_irq_mask[power_mode_pkg::IRQ_T0]  = stop_keep_low_clock && t0_low;
        stop_irq_mask[power_mode_pkg::IRQ_LCD] = stop_keep_low_clock;
        stop_irq_mask[power_mode_pkg::IRQ_ADC] = stop_keep_low_clock && adc_low;
    end

    assign idle_wake_irqs = irq_event_i & irq_enable_i & {power_mode_pkg::IRQ_N{global_irq_enable_i}};
    assign stop_wake_irqs = irq_event_i & irq_enable_i & stop_irq_mask;
    assign idle_wake      = pin_wake || (|idle_wake_irqs);
    assign stop_wake      = pin_wake || (|stop_wake_irqs);

    // Interrupt that woke the device is raised so its service routine follows
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flag_set_o <= '0;
        end else if (ce_i) begin
            if (mode == power_mode_pkg::MODE_IDLE) begin
                irq_flag_set_o <= idle_wake_irqs;
            end else if (mode == power_mode_pkg::MODE_STOP) begin
                irq_flag_set_o <= stop_wake_irqs;
            end else begin
                irq_flag_set_o <= '0;
            end
        end
    end

    // Warm-up length follows the fast source type
    assign fast_target = fast_is_crystal ? power_mode_pkg::FAST_XTAL_WARMUP
                                         : power_mode_pkg::FAST_RC_WARMUP;
    assign warmup_done = (fast_count == fast_target) && (slow_count == power_mode_pkg::SLOW_RC_WARMUP);

    // Fast clocks first, slow RC clocks only after the fast count completes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_count <= 12'h000;
            slow_count <= 3'h0;
        end else if (ce_i) begin
            if (mode != power_mode_pkg::MODE_WARMUP) begin
                fast_count <= 12'h000;
                slow_count <= 3'h0;
            end else if (fast_count != fast_target) begin
                if (fast_tick_i) begin
                    fast_count <= fast_count + 12'h001;
                end
            end else if (slow_count != power_mode_pkg::SLOW_RC_WARMUP) begin
                if (slow_tick_i) begin
                    slow_count <= slow_count + 3'h1;
                end
            end
        end
    end

    always_comb begin
        next_mode = mode;
        case (mode)
            power_mode_pkg::MODE_NORMAL: begin
                if (stop_req) begin
                    next_mode = power_mode_pkg::MODE_STOP;
                end else if (idle_req) begin
                    next_mode = power_mode_pkg::MODE_IDLE;
                end
            end
            power_mode_pkg::MODE_IDLE: begin
                if (idle_wake) begin
                    next_mode = power_mode_pkg::MODE_NORMAL;
                end
            end
            power_mode_pkg::MODE_STOP: begin
                if (stop_wake) begin
                    next_mode = power_mode_pkg::MODE_WARMUP;
                end
            end
            power_mode_pkg::MODE_WARMUP: begin
                if (warmup_done) begin
                    next_mode = power_mode_pkg::MODE_NORMAL;
                end
            end
            default: begin
                next_mode = power_mode_pkg::MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= power_mode_pkg::MODE_NORMAL;
        end else if (ce_i) begin
            mode <= next_mode;
        end
    end

    // Gates follow the next mode so they switch in the same edge as the mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_fast_rc_osc_en_o <= 1'b1;
            fast_crystal_en_o         <= 1'b0;
            internal_slow_rc_osc_en_o <= 1'b1;
            slow_crystal_en_o         <= 1'b0;
            cpu_clock_en_o            <= 1'b1;
            timer_zero_clock_en_o     <= 1'b0;
            timer_one_clock_en_o      <= 1'b0;
            sys_periph_clock_en_o     <= 1'b0;
            lcd_clock_en_o            <= 1'b0;
            adc_clock_en_o            <= 1'b0;
            watchdog_clock_en_o       <= 1'b0;
            ext_irq_en_o              <= 1'b1;
        end else if (ce_i) begin
            // Warm-up keeps the fast source running so it can settle
            if (next_mode == power_mode_pkg::MODE_STOP) begin
                internal_fast_rc_osc_en_o <= 1'b0;
                fast_crystal_en_o         <= 1'b0;
            end else begin
                internal_fast_rc_osc_en_o <= !fast_is_crystal;
                fast_crystal_en_o         <= fast_is_crystal;
            end
            cpu_clock_en_o <= (next_mode == power_mode_pkg::MODE_NORMAL);
            watchdog_clock_en_o <= watchdog_option_i;
            if (next_mode == power_mode_pkg::MODE_NORMAL || next_mode == power_mode_pkg::MODE_IDLE) begin
                internal_slow_rc_osc_en_o <= 1'b1;
                slow_crystal_en_o     <= !low_clock_source_select;
                timer_zero_clock_en_o <= periph_ctrl[power_mode_pkg::PR_T0_RUN_BIT];
                timer_one_clock_en_o  <= periph_ctrl[power_mode_pkg::PR_T1_RUN_BIT];
                sys_periph_clock_en_o <= periph_ctrl[power_mode_pkg::PR_SYS_PERIPH_BIT];
                lcd_clock_en_o        <= periph_ctrl[power_mode_pkg::PR_LCD_EN_BIT];
                adc_clock_en_o        <= periph_ctrl[power_mode_pkg::PR_ADC_EN_BIT];
                ext_irq_en_o          <= 1'b1;
            end else begin
                // Warm-up counts slow RC ticks, so that oscillator stays on then
                internal_slow_rc_osc_en_o <= (stop_keep_low_clock && low_clock_source_select)
                                             || watchdog_option_i
                                             || (next_mode == power_mode_pkg::MODE_WARMUP);
                slow_crystal_en_o     <= stop_keep_low_clock && !low_clock_source_select;
                timer_zero_clock_en_o <= periph_ctrl[power_mode_pkg::PR_T0_RUN_BIT]
                                         && t0_low && stop_keep_low_clock;
                timer_one_clock_en_o  <= 1'b0;
                sys_periph_clock_en_o <= 1'b0;
                lcd_clock_en_o        <= periph_ctrl[power_mode_pkg::PR_LCD_EN_BIT]
                                         && stop_keep_low_clock;
                adc_clock_en_o        <= periph_ctrl[power_mode_pkg::PR_ADC_EN_BIT]
                                         && adc_low && stop_keep_low_clock;
                ext_irq_en_o          <= 1'b0;
            end
        end
    end
endmodule : operating_mode_power_controller
`default_nettype wire

// file: verif/osc_tick_model.sv
// Oscillator tick source seen by the controller
`timescale 1ns/100ps
`default_nettype none
module osc_tick_model #(
    parameter int FP = 2,
    parameter int SP = 8
) (
    input  wire logic clk_i,
    input  wire logic fast_en_i,
    input  wire logic slow_en_i,
    output logic      fast_tick_o,
    output logic      slow_tick_o
);
    int fc = 0;
    int sc = 0;
    initial {fast_tick_o, slow_tick_o} = 2'b00;
    // Ticks stand still while an oscillator is off, so warm-up cannot borrow them
    always @(posedge clk_i) begin
        fc <= fast_en_i ? (fc + 1) % FP : 0;
        sc <= slow_en_i ? (sc + 1) % SP : 0;
        fast_tick_o <= fast_en_i && fc == FP - 1;
        slow_tick_o <= slow_en_i && sc == SP - 1;
    end
endmodule : osc_tick_model
`default_nettype wire

// file: verif/omp_props.sv
// Checker of mode, gate and wake relations
`timescale 1ns/100ps
`default_nettype none
module omp_props (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       watchdog_option_i,
    input wire logic       internal_fast_rc_osc_en_o,
    input wire logic       fast_crystal_en_o,
    input wire logic       internal_slow_rc_osc_en_o,
    input wire logic       slow_crystal_en_o,
    input wire logic       cpu_clock_en_o,
    input wire logic       timer_zero_clock_en_o,
    input wire logic       sys_periph_clock_en_o,
    input wire logic       watchdog_clock_en_o,
    input wire logic       ext_irq_en_o,
    input wire logic [7:0] irq_flag_set_o
);
    logic fast;
    assign fast = internal_fast_rc_osc_en_o | fast_crystal_en_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_stop;
        !cpu_clock_en_o && !fast;
    endsequence
    AST_ONE_FAST: assert property (!(internal_fast_rc_osc_en_o && fast_crystal_en_o)) else $error("two fast");
    AST_CPU_FAST: assert property (cpu_clock_en_o |-> fast) else $error("cpu without fast clock");
    AST_WARMUP: assert property (s_stop |=> !cpu_clock_en_o) else $error("cpu skipped warm-up");
    AST_PERIPH: assert property (sys_periph_clock_en_o |-> fast) else $error("periph clock in stop");
    AST_EXT_OFF: assert property (!ext_irq_en_o |-> !cpu_clock_en_o) else $error("ext irq off in normal");
    AST_EXT_NOWAKE: assert property (s_stop |=> !irq_flag_set_o[7]) else $error("ext irq woke stop");
    AST_T0_SLOW: assert property (timer_zero_clock_en_o && !fast |->
        internal_slow_rc_osc_en_o || slow_crystal_en_o) else $error("timer zero without low clock");
    AST_WDOG: assert property (!$past(rst_i) |-> watchdog_clock_en_o == $past(watchdog_option_i))
        else $error("watchdog not by option");
    AST_FLAG: assert property (|irq_flag_set_o |=> irq_flag_set_o == 8'h00) else $error("flag not a pulse");
endmodule : omp_props
bind operating_mode_power_controller omp_props u_omp_props (.*);
`default_nettype wire

// file: verif/tb_operating_mode_power_controller.sv
// Self-checking bench of the operating mode power controller
`timescale 1ns/100ps
`default_nettype none
module tb_operating_mode_power_controller;
    localparam int FP = 2;
    localparam int SP = 8;
    logic        clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, gie = 1'b0, wdo = 1'b1, clr = 1'b0;
    logic [9:0]  adr = '0;
    logic [31:0] wd = '0, rdata;
    logic [7:0]  p0 = '0, p1 = '0, ev = '0, ien = '0, fl, seen = '0;
    logic        wq, frc, fx, src, cpu, t0, sp, ext, ft, st, sx, t1, lcd, adc, wdc;
    int          mismatches = 0, samples_checked = 0, n, w;
    `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; $display("unexpected at %0t: value differs", $time); end end
    operating_mode_power_controller u_operating_mode_power_controller (.clk_i, .rst_i, .ce_i(1'b1), .address_i(adr),
        .read_i(rd), .write_i(wr), .writedata_i(wd), .byteenable_i(4'h1), .readdata_o(rdata), .waitrequest_o(wq),
        .port_zero_i(p0), .port_one_i(p1), .irq_event_i(ev), .irq_enable_i(ien), .global_irq_enable_i(gie),
        .watchdog_option_i(wdo), .fast_tick_i(ft), .slow_tick_i(st), .internal_fast_rc_osc_en_o(frc),
        .fast_crystal_en_o(fx), .internal_slow_rc_osc_en_o(src), .slow_crystal_en_o(sx), .cpu_clock_en_o(cpu),
        .timer_zero_clock_en_o(t0), .timer_one_clock_en_o(t1), .sys_periph_clock_en_o(sp), .lcd_clock_en_o(lcd),
        .adc_clock_en_o(adc), .watchdog_clock_en_o(wdc), .ext_irq_en_o(ext), .irq_flag_set_o(fl));
    osc_tick_model #(.FP(FP), .SP(SP)) u_osc_tick_model (.clk_i, .fast_en_i(frc | fx), .slow_en_i(src),
        .fast_tick_o(ft), .slow_tick_o(st));
    initial forever #2.5 clk_i = ~clk_i;
    // Single driver of the wake flag log; cleared through a request, not from the test process
    always @(posedge clk_i) seen <= clr ? 8'h00 : (seen | fl);
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask : cyc
    // Read compares low byte and zero upper bits; master holds until waitrequest low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        adr <= {idx, 2'b00};
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wq !== 1'b0);
        if (!w) `CHK(rdata, {24'h0, d})
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic enter(input logic [7:0] v);
        bus(1, power_mode_pkg::IDX_POWER_CONTROL, v);
        cyc(2);
    endtask : enter
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 8'h00;
    endtask : pulse
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        #300000;
        mismatches++;
        final_report();
    end
    initial begin
        cyc(3);
        rst_i <= 1'b0;
        cyc(1);
        `CHK({cpu, frc, fx, ext}, 4'b1101)
        bus(0, power_mode_pkg::IDX_POWER_CONTROL, 8'h00);
        bus(0, power_mode_pkg::IDX_PORT_ONE_WAKE, 8'h00);
        bus(0, power_mode_pkg::IDX_MODE_STATUS, 8'h11);
        bus(0, 8'h12, 8'h00);
        $display("test reset done");
        bus(1, power_mode_pkg::IDX_PERIPH_CTRL, 8'h5b);
        enter(8'h01);
        `CHK({cpu, sp, frc, lcd, adc, t1}, 6'b011110)
        p1 <= 8'h08;
        cyc(4);
        `CHK(cpu, 1'b0)
        bus(1, power_mode_pkg::IDX_PORT_ONE_WAKE, 8'h08);
        p1 <= 8'h00;
        cyc(4);
        `CHK(cpu, 1'b1)
        bus(0, power_mode_pkg::IDX_POWER_CONTROL, 8'h00);
        ien <= 8'h91;
        enter(8'h01);
        pulse(8'h10);
        cyc(4);
        `CHK(cpu, 1'b0)
        gie <= 1'b1;
        pulse(8'h10);
        cyc(4);
        `CHK({cpu, seen[power_mode_pkg::IRQ_UART]}, 2'b11)
        $display("test idle done");
        bus(1, power_mode_pkg::IDX_LOW_CLOCK_KEEP, 8'h01);
        for (int i = 0; i < 2; i++) begin
            w = i ? power_mode_pkg::FAST_XTAL_WARMUP : power_mode_pkg::FAST_RC_WARMUP;
            bus(1, power_mode_pkg::IDX_CLOCK_SELECT, {7'h40, i[0]});
            // Gates pick up the new source one edge after the register changes
            cyc(2);
            `CHK({frc, fx}, {!i[0], i[0]})
            enter(8'h03);
            `CHK({cpu, frc, fx, src, t0, sp, ext, lcd, adc, t1, sx, wdc}, 12'b000110010001)
            pulse(8'h80);
            cyc(4);
            `CHK(cpu, 1'b0)
            clr <= 1'b1;
            cyc(1);
            clr <= 1'b0;
            if (i) pulse(8'h01);
            else p0 <= ~p0;
            n = 0;
            while (cpu !== 1'b1 && n < 9000) begin
                @(posedge clk_i);
                n++;
            end
            `CHK(n >= w * FP + 4 * SP && n <= w * FP + 5 * SP + 12, 1'b1)
            `CHK(seen[0], i[0])
            bus(0, power_mode_pkg::IDX_POWER_CONTROL, 8'h00);
        end
        $display("test stop done");
        final_report();
    end
endmodule : tb_operating_mode_power_controller
`default_nettype wire
